// file: src/psf_pkg.sv
// Constants, types and field layout of the program status flags block
// Functional notes
// - Add or subtract sets carry on carry out of, or borrow into, bit 7.
// - Multiply and divide always leave the carry flag cleared.
// - Decimal adjust sets carry when the decimal sum passed two digits.
// - Compare-and-branch sets carry when first unsigned operand is below second.
// - Aux carry shows carry out of, or borrow into, the low nibble.
// - User flags at bits 5 and 1 change only by software writes.
// - Bank select 00 maps registers to 00H-07H, 11 maps to 18H-1FH.
// - Add ops set overflow when exactly one of bit 6, bit 7 carries.
// - Subtract with borrow sets overflow when exactly one of bits 6, 7 borrows.
// - Multiply sets overflow when the product's upper byte is nonzero.
// - Divide clears overflow, but sets it for a zero divisor.
// - Parity bit always shows odd count of ones in the accumulator.
// - Status word sits at address D0H and each bit is addressable.
package psf_pkg;

  // Register location and bit addressing
  localparam logic [7:0] PSF_STATUS_ADDR = 8'hD0;
  localparam logic [4:0] PSF_BIT_BASE    = 5'h1A;
  localparam logic [7:0] PSF_RESET_VALUE = 8'h00;

  // Field positions inside the status word
  localparam int PSF_POS_CARRY  = 7;
  localparam int PSF_POS_AUX    = 6;
  localparam int PSF_POS_USER0  = 5;
  localparam int PSF_POS_BANKHI = 4;
  localparam int PSF_POS_BANKLO = 3;
  localparam int PSF_POS_OVF    = 2;
  localparam int PSF_POS_USER1  = 1;
  localparam int PSF_POS_PARITY = 0;

  // Arithmetic limits
  localparam logic [3:0] PSF_BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] PSF_BCD_LOW_ADJ   = 8'h06;
  localparam logic [7:0] PSF_BCD_HIGH_ADJ  = 8'h60;
  localparam logic [7:0] PSF_ZERO_BYTE     = 8'h00;

  // Instructions whose result flags this block computes
  typedef enum logic [2:0] {
    PSF_OP_ADD,
    PSF_OP_ADD_WITH_CARRY,
    PSF_OP_SUBTRACT_WITH_BORROW,
    PSF_OP_MULTIPLY,
    PSF_OP_DIVIDE,
    PSF_OP_DECIMAL_ADJUST,
    PSF_OP_COMPARE_BRANCH
  } psf_op_t;

  // Flag update request from the instruction datapath
  typedef struct packed {
    logic       valid;
    psf_op_t    op;
    logic [7:0] opnd_a;
    logic [7:0] opnd_b;
  } psf_alu_req_t;

  // Byte access in special-function space
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } psf_sfr_req_t;

  // Single-bit access in bit space
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic       value;
  } psf_bit_req_t;

  // Whole state of the block
  typedef struct packed {
    logic       carry_flag;
    logic       aux_carry_flag;
    logic       user_flag_zero;
    logic       bank_select_high;
    logic       bank_select_low;
    logic       overflow_flag;
    logic       user_flag_one;
    logic [7:0] sfr_rdata;
    logic       bit_rdata;
  } psf_state_t;

endpackage : psf_pkg

// file: src/psf_status_word.sv
// Program status word with result flags, user flags and bank select
`timescale 1ns/1ns
module psf_status_word (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Instruction datapath
  input  wire psf_pkg::psf_alu_req_t alu_req_i,
  input  wire logic [7:0]        acc_i,
  // Special-function byte and bit access
  input  wire psf_pkg::psf_sfr_req_t sfr_req_i,
  input  wire psf_pkg::psf_bit_req_t bit_req_i,
  output logic [7:0]             sfr_rdata_o,
  output logic                   bit_rdata_o,
  // Status towards the core
  output logic [7:0]             program_status_word_o,
  output logic [7:0]             bank_base_o
);

  // Nine-bit sum with carry in
  function automatic logic [8:0] psf_add9(input logic [7:0] a, input logic [7:0] b,
                                          input logic cin);
    return {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction

  // Nine-bit difference with borrow in; bit 8 is the borrow out
  function automatic logic [8:0] psf_sub9(input logic [7:0] a, input logic [7:0] b,
                                          input logic bin);
    return {1'b0, a} - {1'b0, b} - {8'h00, bin};
  endfunction

  psf_pkg::psf_state_t state_reg;
  psf_pkg::psf_state_t state_next;

  logic       parity;
  logic [7:0] image;
  logic       byte_hit;
  logic       bit_hit;
  logic [2:0] bit_idx;

  // Live parity of the accumulator
  // parity from accumulator
  assign parity = ^acc_i;

  // Current status word image
  // parity never stored
  always_comb begin
    image = 8'h00;
    image[psf_pkg::PSF_POS_CARRY]  = state_reg.carry_flag;
    image[psf_pkg::PSF_POS_AUX]    = state_reg.aux_carry_flag;
    image[psf_pkg::PSF_POS_USER0]  = state_reg.user_flag_zero;
    image[psf_pkg::PSF_POS_BANKHI] = state_reg.bank_select_high;
    image[psf_pkg::PSF_POS_BANKLO] = state_reg.bank_select_low;
    image[psf_pkg::PSF_POS_OVF]    = state_reg.overflow_flag;
    image[psf_pkg::PSF_POS_USER1]  = state_reg.user_flag_one;
    image[psf_pkg::PSF_POS_PARITY] = parity;
  end

  // Address decode for byte and bit space
  // byte and bit decode
  assign byte_hit = (sfr_req_i.addr == psf_pkg::PSF_STATUS_ADDR);
  assign bit_hit  = (bit_req_i.addr[7:3] == psf_pkg::PSF_BIT_BASE);
  assign bit_idx  = bit_req_i.addr[2:0];

  // Next-state logic: software access first, then instruction flags override
  always_comb begin
    logic [7:0] wimg;
    logic [8:0] full;
    logic [8:0] low7;
    logic [8:0] nib;
    logic [8:0] adj;
    logic [15:0] prod;
    logic        cin;
    wimg  = image;
    full  = 9'h000;
    low7  = 9'h000;
    nib   = 9'h000;
    adj   = 9'h000;
    prod  = 16'h0000;
    cin   = 1'b0;
    state_next = state_reg;

    // Software writes, byte then bit
    // user flags by software
    if (sfr_req_i.wr && byte_hit) begin
      wimg = sfr_req_i.wdata;
    end
    if (bit_req_i.wr && bit_hit) begin
      wimg[bit_idx] = bit_req_i.value;
    end
    state_next.carry_flag       = wimg[psf_pkg::PSF_POS_CARRY];
    state_next.aux_carry_flag   = wimg[psf_pkg::PSF_POS_AUX];
    state_next.user_flag_zero   = wimg[psf_pkg::PSF_POS_USER0];
    state_next.bank_select_high = wimg[psf_pkg::PSF_POS_BANKHI];
    state_next.bank_select_low  = wimg[psf_pkg::PSF_POS_BANKLO];
    state_next.overflow_flag    = wimg[psf_pkg::PSF_POS_OVF];
    state_next.user_flag_one    = wimg[psf_pkg::PSF_POS_USER1];

    // Instruction flag results win over a same-cycle software write
    if (alu_req_i.valid) begin
      unique case (alu_req_i.op)
        psf_pkg::PSF_OP_ADD,
        psf_pkg::PSF_OP_ADD_WITH_CARRY: begin
          cin  = (alu_req_i.op == psf_pkg::PSF_OP_ADD_WITH_CARRY) ? state_reg.carry_flag
                                                                 : 1'b0;
          full = psf_add9(alu_req_i.opnd_a, alu_req_i.opnd_b, cin);
          low7 = psf_add9({1'b0, alu_req_i.opnd_a[6:0]}, {1'b0, alu_req_i.opnd_b[6:0]}, cin);
          nib  = psf_add9({4'h0, alu_req_i.opnd_a[3:0]}, {4'h0, alu_req_i.opnd_b[3:0]}, cin);
          state_next.carry_flag     = full[8];
          state_next.aux_carry_flag = nib[4];
          // carries at bits 6 and 7
          state_next.overflow_flag  = full[8] ^ low7[7];
        end
        psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW: begin
          cin  = state_reg.carry_flag;
          full = psf_sub9(alu_req_i.opnd_a, alu_req_i.opnd_b, cin);
          low7 = psf_sub9({1'b0, alu_req_i.opnd_a[6:0]}, {1'b0, alu_req_i.opnd_b[6:0]}, cin);
          nib  = psf_sub9({4'h0, alu_req_i.opnd_a[3:0]}, {4'h0, alu_req_i.opnd_b[3:0]}, cin);
          state_next.carry_flag     = full[8];
          state_next.aux_carry_flag = nib[4];
          // borrows at bits 6 and 7
          state_next.overflow_flag  = full[8] ^ low7[7];
        end
        psf_pkg::PSF_OP_MULTIPLY: begin
          prod = {8'h00, alu_req_i.opnd_a} * {8'h00, alu_req_i.opnd_b};
          state_next.carry_flag    = 1'b0;
          state_next.overflow_flag = (prod[15:8] != psf_pkg::PSF_ZERO_BYTE);
        end
        psf_pkg::PSF_OP_DIVIDE: begin
          state_next.carry_flag    = 1'b0;
          state_next.overflow_flag = (alu_req_i.opnd_b == psf_pkg::PSF_ZERO_BYTE);
        end
        psf_pkg::PSF_OP_DECIMAL_ADJUST: begin
          // Low digit correction, then high digit correction on operand a
          adj = {1'b0, alu_req_i.opnd_a};
          if ((alu_req_i.opnd_a[3:0] > psf_pkg::PSF_BCD_DIGIT_MAX) ||
              state_reg.aux_carry_flag) begin
            adj = psf_add9(alu_req_i.opnd_a, psf_pkg::PSF_BCD_LOW_ADJ, 1'b0);
          end
          cin = adj[8];
          if (cin || (adj[7:4] > psf_pkg::PSF_BCD_DIGIT_MAX) || state_reg.carry_flag) begin
            adj = psf_add9(adj[7:0], psf_pkg::PSF_BCD_HIGH_ADJ, 1'b0);
          end
          // carry for sum of 100 or more
          state_next.carry_flag = state_reg.carry_flag | cin | adj[8];
        end
        psf_pkg::PSF_OP_COMPARE_BRANCH: begin
          state_next.carry_flag = (alu_req_i.opnd_a < alu_req_i.opnd_b);
        end
        // Unused opcode leaves the flags as written
        default: begin
        end
      endcase
    end

    // Registered read data; unmapped addresses read zero
    // readable by byte and bit
    if (sfr_req_i.rd) begin
      state_next.sfr_rdata = byte_hit ? image : 8'h00;
    end
    if (bit_req_i.rd) begin
      state_next.bit_rdata = bit_hit ? image[bit_idx] : 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= '{carry_flag:       psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_CARRY],
                     aux_carry_flag:   psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_AUX],
                     user_flag_zero:   psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_USER0],
                     bank_select_high: psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_BANKHI],
                     bank_select_low:  psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_BANKLO],
                     overflow_flag:    psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_OVF],
                     user_flag_one:    psf_pkg::PSF_RESET_VALUE[psf_pkg::PSF_POS_USER1],
                     sfr_rdata:        8'h00,
                     bit_rdata:        1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs
  // bank base address
  assign bank_base_o           = {3'b000, state_reg.bank_select_high,
                                  state_reg.bank_select_low, 3'b000};
  assign program_status_word_o = image;
  assign sfr_rdata_o           = state_reg.sfr_rdata;
  assign bit_rdata_o           = state_reg.bit_rdata;

  // Signed reference results, worked apart from the flag logic, for the checks
  logic       ref_cin;
  logic [8:0] ref_sum;
  logic [8:0] ref_diff;
  assign ref_cin  = (alu_req_i.op == psf_pkg::PSF_OP_ADD_WITH_CARRY) && state_reg.carry_flag;
  assign ref_sum  = {alu_req_i.opnd_a[7], alu_req_i.opnd_a} +
                    {alu_req_i.opnd_b[7], alu_req_i.opnd_b} +
                    {8'h00, ref_cin};
  assign ref_diff = {alu_req_i.opnd_a[7], alu_req_i.opnd_a} -
                    {alu_req_i.opnd_b[7], alu_req_i.opnd_b} -
                    {8'h00, state_reg.carry_flag};

  // Checks on flag results
  carry_add_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_ADD) |=>
    state_reg.carry_flag == (({1'b0, $past(alu_req_i.opnd_a)} +
                               {1'b0, $past(alu_req_i.opnd_b)}) > 9'h0FF))
    else $error("carry wrong after add");

  carry_muldiv_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && (alu_req_i.op == psf_pkg::PSF_OP_MULTIPLY ||
                         alu_req_i.op == psf_pkg::PSF_OP_DIVIDE)) |=> !state_reg.carry_flag)
    else $error("carry set after multiply or divide");

  carry_decadj_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_DECIMAL_ADJUST &&
     (state_reg.carry_flag || alu_req_i.opnd_a > 8'h99)) |=> state_reg.carry_flag)
    else $error("decimal adjust lost carry");

  carry_compare_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_COMPARE_BRANCH) |=>
    state_reg.carry_flag == ($past(alu_req_i.opnd_a) < $past(alu_req_i.opnd_b)))
    else $error("carry wrong after compare");

  aux_add_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_ADD) |=>
    state_reg.aux_carry_flag == (({1'b0, $past(alu_req_i.opnd_a[3:0])} +
                                  {1'b0, $past(alu_req_i.opnd_b[3:0])}) > 5'h0F))
    else $error("aux carry wrong after add");

  user_flags_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !(sfr_req_i.wr && byte_hit) && !(bit_req_i.wr && bit_hit) |=>
    $stable(state_reg.user_flag_zero) && $stable(state_reg.user_flag_one))
    else $error("user flag changed without software");

  bank_map_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sfr_req_i.wr && byte_hit && !(bit_req_i.wr && bit_hit)) |=>
    bank_base_o == {6'h00, $past(sfr_req_i.wdata[4:3])} * 8'h08)
    else $error("bank base does not follow select");

  ovf_add_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_ADD &&
     alu_req_i.opnd_a == 8'h7F && alu_req_i.opnd_b == 8'h01) |=> state_reg.overflow_flag)
    else $error("overflow missed on positive add");

  ovf_mult_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_MULTIPLY) |=>
    state_reg.overflow_flag == (({8'h00, $past(alu_req_i.opnd_a)} *
                                 {8'h00, $past(alu_req_i.opnd_b)}) > 16'h00FF))
    else $error("overflow wrong after multiply");

  ovf_divide_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_DIVIDE) |=>
    state_reg.overflow_flag == ($past(alu_req_i.opnd_b) == 8'h00))
    else $error("overflow wrong after divide");

  parity_live_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    program_status_word_o[0] == ($countones(acc_i) % 2 == 1))
    else $error("parity does not match accumulator");

  byte_read_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sfr_req_i.rd && sfr_req_i.addr == 8'hD0) |=> sfr_rdata_o == $past(program_status_word_o))
    else $error("byte read of status word wrong");

  ovf_add_with_carry_op_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && (alu_req_i.op == psf_pkg::PSF_OP_ADD ||
                         alu_req_i.op == psf_pkg::PSF_OP_ADD_WITH_CARRY)) |=>
    state_reg.overflow_flag == ($past(ref_sum[8]) != $past(ref_sum[7])))
    else $error("overflow wrong after add");

  ovf_sub_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW) |=>
    state_reg.overflow_flag == ($past(ref_diff[8]) != $past(ref_diff[7])))
    else $error("overflow wrong after subtract");

  aux_sub_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (alu_req_i.valid && alu_req_i.op == psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW) |=>
    state_reg.aux_carry_flag == ({1'b0, $past(alu_req_i.opnd_a[3:0])} <
                                 {1'b0, $past(alu_req_i.opnd_b[3:0])} +
                                 {4'h0, $past(state_reg.carry_flag)}))
    else $error("aux carry wrong after subtract");

  // Checks on software access
  byte_write_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (sfr_req_i.wr && byte_hit && !alu_req_i.valid && !(bit_req_i.wr && bit_hit)) |=>
    program_status_word_o[7:1] == $past(sfr_req_i.wdata[7:1]))
    else $error("byte write not kept in status word");

  bit_write_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (bit_req_i.wr && bit_hit && bit_idx != 3'h0 && !alu_req_i.valid) |=>
    program_status_word_o[$past(bit_idx)] == $past(bit_req_i.value))
    else $error("bit write not kept in status word");

  bit_read_a : assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (bit_req_i.rd && bit_hit) |=>
    bit_rdata_o == $past(program_status_word_o[bit_idx]))
    else $error("bit read of status word wrong");

endmodule // psf_status_word

// file: dv/psf_status_word_tb.sv
// Self-checking bench for the program status word block
`timescale 1ns/1ns
module psf_status_word_tb;
  // Flag table row: word written first, operation, accumulator, expected word
  typedef struct packed {
    psf_pkg::psf_op_t op;
    logic [7:0]       pre;
    logic [7:0]       a;
    logic [7:0]       b;
    logic [7:0]       acc;
    logic [7:0]       expv;
  } psf_row_t;

  logic                  clk_i           = 1'b0;
  logic                  reset_n_i       = 1'b0;
  psf_pkg::psf_alu_req_t alu_req         = '0;
  logic [7:0]            acc             = 8'h01;
  psf_pkg::psf_sfr_req_t sfr_req         = '0;
  psf_pkg::psf_bit_req_t bit_req         = '0;
  logic [7:0]            sfr_rdata;
  logic                  bit_rdata;
  logic [7:0]            program_status_word;
  logic [7:0]            bank_base;
  int                    n_errors        = 0;
  int                    samples_checked = 0;
  logic [7:0]            expw;
  psf_row_t              rows [16]       = '{
    '{psf_pkg::PSF_OP_ADD, 8'h00, 8'h7F, 8'h01, 8'h00, 8'h44},
    '{psf_pkg::PSF_OP_ADD, 8'h00, 8'hFF, 8'h01, 8'h01, 8'hC1},
    '{psf_pkg::PSF_OP_ADD, 8'h3A, 8'h80, 8'h80, 8'h03, 8'hBE},
    '{psf_pkg::PSF_OP_ADD_WITH_CARRY, 8'h80, 8'h0F, 8'h00, 8'h00, 8'h40},
    '{psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW, 8'h00, 8'h00, 8'h01, 8'h00, 8'hC0},
    '{psf_pkg::PSF_OP_SUBTRACT_WITH_BORROW, 8'h80, 8'h80, 8'h00, 8'h00, 8'h44},
    '{psf_pkg::PSF_OP_MULTIPLY, 8'hC0, 8'h10, 8'h10, 8'h00, 8'h44},
    '{psf_pkg::PSF_OP_MULTIPLY, 8'h84, 8'h0F, 8'h11, 8'h00, 8'h00},
    '{psf_pkg::PSF_OP_DIVIDE, 8'h80, 8'h10, 8'h00, 8'h00, 8'h04},
    '{psf_pkg::PSF_OP_DIVIDE, 8'h84, 8'h10, 8'h02, 8'h00, 8'h00},
    '{psf_pkg::PSF_OP_DECIMAL_ADJUST, 8'h00, 8'h9A, 8'h00, 8'h00, 8'h80},
    '{psf_pkg::PSF_OP_DECIMAL_ADJUST, 8'h00, 8'h45, 8'h00, 8'h00, 8'h00},
    '{psf_pkg::PSF_OP_DECIMAL_ADJUST, 8'h80, 8'h12, 8'h00, 8'h00, 8'h80},
    '{psf_pkg::PSF_OP_COMPARE_BRANCH, 8'h00, 8'h10, 8'h20, 8'h00, 8'h80},
    '{psf_pkg::PSF_OP_COMPARE_BRANCH, 8'h80, 8'h20, 8'h10, 8'h00, 8'h00},
    '{psf_pkg::PSF_OP_COMPARE_BRANCH, 8'h80, 8'h33, 8'h33, 8'h00, 8'h00}
  };

  // Free-running core clock, 4 ns period
  always #2 clk_i = ~clk_i;

  // Block under test
  psf_status_word dut_u (
    .clk_i                 (clk_i),
    .reset_n_i             (reset_n_i),
    .alu_req_i             (alu_req),
    .acc_i                 (acc),
    .sfr_req_i             (sfr_req),
    .bit_req_i             (bit_req),
    .sfr_rdata_o           (sfr_rdata),
    .bit_rdata_o           (bit_rdata),
    .program_status_word_o (program_status_word),
    .bank_base_o           (bank_base)
  );

  // Compares one byte result and counts it
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Prints the verdict and ends the run
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Byte access, one cycle strobe, result visible at the next falling edge
  task automatic sfr(input logic wr, input logic rd, input logic [7:0] ad, input logic [7:0] wd);
    @(negedge clk_i);
    sfr_req = '{wr: wr, rd: rd, addr: ad, wdata: wd};
    @(negedge clk_i);
    sfr_req = '0;
  endtask

  // Single-bit access, one cycle strobe
  task automatic bitacc(input logic wr, input logic rd, input logic [7:0] ad, input logic v);
    @(negedge clk_i);
    bit_req = '{wr: wr, rd: rd, addr: ad, value: v};
    @(negedge clk_i);
    bit_req = '0;
  endtask

  // Flag update request for one instruction
  task automatic alu(input psf_pkg::psf_op_t op, input logic [7:0] a, input logic [7:0] b);
    @(negedge clk_i);
    alu_req = '{valid: 1'b1, op: op, opnd_a: a, opnd_b: b};
    @(negedge clk_i);
    alu_req = '0;
  endtask

  // Cuts a hung run short
  initial begin
    #40000;
    n_errors++;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (10) @(negedge clk_i);
    chk8(program_status_word, 8'h01);
    chk8(bank_base, 8'h00);
    chk8(sfr_rdata, 8'h00);
    reset_n_i = 1'b1;
    // Flag table, each row from a freshly written word
    foreach (rows[i]) begin
      acc = rows[i].acc;
      sfr(1'b1, 1'b0, psf_pkg::PSF_STATUS_ADDR, rows[i].pre);
      alu(rows[i].op, rows[i].a, rows[i].b);
      chk8(program_status_word, rows[i].expv);
    end
    // Byte writes, reads and an unmapped read
    acc = 8'h00;
    sfr(1'b1, 1'b0, 8'hD0, 8'hFF);
    chk8(program_status_word, 8'hFE);
    chk8(bank_base, 8'h18);
    sfr(1'b0, 1'b1, 8'hD0, 8'h00);
    chk8(sfr_rdata, 8'hFE);
    sfr(1'b0, 1'b1, 8'hD1, 8'h00);
    chk8(sfr_rdata, 8'h00);
    for (int n = 0; n < 4; n++) begin
      expw = 8'(n * 8);
      sfr(1'b1, 1'b0, 8'hD0, expw);
      chk8(bank_base, expw);
    end
    // Bit writes one position at a time
    sfr(1'b1, 1'b0, 8'hD0, 8'h00);
    expw = 8'h00;
    for (int n = 1; n < 8; n++) begin
      bitacc(1'b1, 1'b0, 8'hD0 + 8'(n), 1'b1);
      expw[n] = 1'b1;
      chk8(program_status_word, expw);
    end
    bitacc(1'b1, 1'b0, 8'hD0, 1'b1);
    chk8(program_status_word, 8'hFE);
    bitacc(1'b1, 1'b0, 8'hD7, 1'b0);
    chk8(program_status_word, 8'h7E);
    bitacc(1'b0, 1'b1, 8'hD5, 1'b0);
    chk8({7'h00, bit_rdata}, 8'h01);
    // Arithmetic leaves user flags and bank alone
    alu(psf_pkg::PSF_OP_ADD, 8'h01, 8'h01);
    chk8(program_status_word, 8'h3A);
    acc = 8'h07;
    #1;
    chk8(program_status_word, 8'h3B);
    // Same-cycle write and arithmetic update
    @(negedge clk_i);
    acc = 8'h00;
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: 8'hD0, wdata: 8'hC4};
    alu_req = '{valid: 1'b1, op: psf_pkg::PSF_OP_ADD, opnd_a: 8'h01, opnd_b: 8'h01};
    @(negedge clk_i);
    sfr_req = '0;
    alu_req = '0;
    chk8(program_status_word, 8'h00);
    // Fill flags and both read registers so that reset has work to do
    sfr(1'b1, 1'b0, 8'hD0, 8'hFF);
    sfr(1'b0, 1'b1, 8'hD0, 8'h00);
    chk8(sfr_rdata, 8'hFE);
    bitacc(1'b0, 1'b1, 8'hD7, 1'b0);
    chk8({7'h00, bit_rdata}, 8'h01);
    // Reset in mid-run
    @(negedge clk_i);
    reset_n_i = 1'b0;
    #1;
    chk8(program_status_word, 8'h00);
    chk8(bank_base, 8'h00);
    chk8(sfr_rdata, 8'h00);
    chk8({7'h00, bit_rdata}, 8'h00);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    sfr(1'b1, 1'b0, 8'hD0, 8'h18);
    chk8(bank_base, 8'h18);
    sfr(1'b0, 1'b1, 8'hD0, 8'h00);
    chk8(sfr_rdata, 8'h18);
    summarize();
  end
endmodule // psf_status_word_tb
